// ### osc_ctl_pkg.sv
// Functional notes
// - Unlock needs E7H then 18H, in order
// - Next write stores value, then relocks
// - Any other write sequence changes nothing
// - Bit 7 enables the precision oscillator
// - Bit 5 enables the watchdog oscillator
// - Bit 4 enables primary failure detect, recovery
// - Bit 3 enables watchdog failure detection
// - Select 000 fast, 001 slow, 011 watchdog
// - Select 100 picks the external clock pin
// - Bit 6 reserved, always reads zero
// - Selected source becomes the system clock
// - Primary failure forces watchdog clock, raises event, if watchdog osc is on, not failed, not selected
// - 8004 cycles without watchdog edge means failure
`default_nettype none
package osc_ctl_pkg;

	// ----------------------------------------
	// Register map (index, byte address = 4 x index)
	// ----------------------------------------
	localparam int              ADDR_W      = 16;
	localparam logic [11:0]     CTRL_IDX    = 12'hf86;
	localparam logic [11:0]     STATUS_IDX  = 12'hf87;
	localparam logic [11:0]     MASK_IDX    = 12'hf88;
	localparam logic [15:0]     CTRL_ADDR   = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [15:0]     STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};
	localparam logic [15:0]     MASK_ADDR   = {2'h0, MASK_IDX, 2'h0};

	// ----------------------------------------
	// Control register layout
	// ----------------------------------------
	localparam logic [7:0]      CTRL_RESET  = 8'ha0;
	localparam logic [7:0]      CTRL_WMASK  = 8'hbf;
	localparam logic [7:0]      UNLOCK_KEY1 = 8'he7;
	localparam logic [7:0]      UNLOCK_KEY2 = 8'h18;
	localparam int              PREC_EN_BIT = 7;
	localparam int              WDT_EN_BIT  = 5;
	localparam int              PFD_EN_BIT  = 4;
	localparam int              WFD_EN_BIT  = 3;
	localparam int              SEL_MSB     = 2;

	// ----------------------------------------
	// Clock select codes
	// ----------------------------------------
	localparam logic [2:0]      SEL_PREC_FAST = 3'h0;
	localparam logic [2:0]      SEL_PREC_SLOW = 3'h1;
	localparam logic [2:0]      SEL_WDT       = 3'h3;
	localparam logic [2:0]      SEL_EXT       = 3'h4;

	// ----------------------------------------
	// Status, bus answers, timing
	// ----------------------------------------
	localparam int              PFAIL_BIT   = 0;
	localparam int              WFAIL_BIT   = 1;
	localparam logic [1:0]      RESP_OKAY   = 2'h0;
	localparam logic [1:0]      RESP_SLVERR = 2'h2;
	localparam int              WDT_FAIL_CYCLES = 32'h1f44; // 8004 system clocks

	typedef enum logic [1:0] {LOCKED, KEY1_SEEN, UNLOCKED} lock_t;

endpackage
`default_nettype wire

// ### oscillator_select_lock.sv
`timescale 1ns/1ps
`default_nettype none
module oscillator_select_lock
	import osc_ctl_pkg::*;
#(
	parameter int WDT_FAIL_LIMIT = WDT_FAIL_CYCLES,
	parameter int CNT_W          = 14
)(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	// AXI4-Lite write response
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Oscillator monitors
	input  wire logic              primary_clock_failed,
	input  wire logic              watchdog_osc_tick,
	// Oscillator controls
	output var  logic              precision_osc_enable,
	output var  logic              watchdog_osc_enable,
	output var  logic [2:0]        system_clock_select,
	// Failure events
	output var  logic              primary_fail_event,
	output var  logic              watchdog_fail_event,
	output var  logic              irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]        ctrl;
		lock_t             lock;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [7:0]        wdata;
		logic              wstrb0;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [1:0]        status;
		logic [1:0]        mask;
		logic [CNT_W-1:0]  wdt_cnt;
		logic              wdt_failed;
		logic              fallback;
		logic              pfail_evt;
		logic              wfail_evt;
	} state_t;

	localparam logic [CNT_W-1:0] WDT_LAST = CNT_W'(WDT_FAIL_LIMIT - 1);

	state_t s_r;
	state_t s_nxt;
	logic   wr_fire;
	logic   rd_fire;
	logic   ctrl_wr;
	logic   pfail_now;
	logic   wfail_now;
	logic   wdt_watch;

	// ----------------------------------------
	// Bus strobes and failure conditions
	// ----------------------------------------
	assign wr_fire   = s_r.aw_got && s_r.w_got && !s_r.bvalid;
	assign rd_fire   = s_axi_arvalid && !s_r.rvalid;
	assign ctrl_wr   = wr_fire && s_r.awaddr == CTRL_ADDR && s_r.wstrb0;
	// Recovery needs a live watchdog clock and is pointless when already on it
	assign pfail_now = s_r.ctrl[PFD_EN_BIT] && primary_clock_failed && !s_r.fallback
		&& s_r.ctrl[WDT_EN_BIT] && !s_r.wdt_failed
		&& s_r.ctrl[SEL_MSB:0] != SEL_WDT;
	assign wdt_watch = s_r.ctrl[WFD_EN_BIT] && !s_r.wdt_failed;
	assign wfail_now = wdt_watch && !watchdog_osc_tick && s_r.wdt_cnt == WDT_LAST;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_nxt           = s_r;
		s_nxt.pfail_evt = 1'b0;
		s_nxt.wfail_evt = 1'b0;

		// Address and data may arrive in either order
		if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid)
		begin
			s_nxt.w_got  = 1'b1;
			s_nxt.wdata  = s_axi_wdata[7:0];
			s_nxt.wstrb0 = s_axi_wstrb[0];
		end

		// Write execution; unlock keys only count when aimed at the control byte
		if (wr_fire)
		begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = RESP_OKAY;
			if (ctrl_wr)
			begin
				unique case (s_r.lock)
					LOCKED:
						s_nxt.lock = (s_r.wdata == UNLOCK_KEY1) ? KEY1_SEEN : LOCKED;
					KEY1_SEEN:
						if (s_r.wdata == UNLOCK_KEY2)
							s_nxt.lock = UNLOCKED;
						else if (s_r.wdata != UNLOCK_KEY1)
							s_nxt.lock = LOCKED;
					UNLOCKED:
					begin
						// Reserved bit is dropped so it always reads zero
						s_nxt.ctrl     = s_r.wdata & CTRL_WMASK;
						s_nxt.lock     = LOCKED;
						s_nxt.fallback = 1'b0;
					end
				endcase
			end
			else if (s_r.awaddr == MASK_ADDR)
			begin
				if (s_r.wstrb0)
					s_nxt.mask = s_r.wdata[1:0];
			end
			else if (s_r.awaddr != CTRL_ADDR && s_r.awaddr != STATUS_ADDR)
				s_nxt.bresp = RESP_SLVERR;
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;

		// Read path; a status read clears what it returned
		if (rd_fire)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = RESP_OKAY;
			s_nxt.rdata  = 32'h0;
			if (s_axi_araddr == CTRL_ADDR)
				s_nxt.rdata[7:0] = s_r.ctrl;
			else if (s_axi_araddr == STATUS_ADDR)
			begin
				s_nxt.rdata[1:0] = s_r.status;
				s_nxt.status     = 2'h0;
			end
			else if (s_axi_araddr == MASK_ADDR)
				s_nxt.rdata[1:0] = s_r.mask;
			else
				s_nxt.rresp = RESP_SLVERR;
		end
		else if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;

		// Watchdog oscillator monitor counts clocks between its edges
		if (!s_r.ctrl[WFD_EN_BIT])
		begin
			s_nxt.wdt_cnt    = '0;
			s_nxt.wdt_failed = 1'b0;
		end
		else if (wdt_watch)
		begin
			if (watchdog_osc_tick)
				s_nxt.wdt_cnt = '0;
			else if (wfail_now)
			begin
				s_nxt.wdt_failed = 1'b1;
				s_nxt.wfail_evt  = 1'b1;
			end
			else
				s_nxt.wdt_cnt = s_r.wdt_cnt + 1'b1;
		end

		// Primary failure switches to the watchdog clock until rewritten
		if (pfail_now)
		begin
			s_nxt.fallback  = 1'b1;
			s_nxt.pfail_evt = 1'b1;
		end

		// Events win over a clearing read in the same cycle
		if (pfail_now)
			s_nxt.status[PFAIL_BIT] = 1'b1;
		if (wfail_now)
			s_nxt.status[WFAIL_BIT] = 1'b1;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r      <= '0;
			s_r.ctrl <= CTRL_RESET;
			s_r.lock <= LOCKED;
		end
		else
			s_r <= s_nxt;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready        = !s_r.aw_got && !s_r.bvalid;
	assign s_axi_wready         = !s_r.w_got && !s_r.bvalid;
	assign s_axi_bvalid         = s_r.bvalid;
	assign s_axi_bresp          = s_r.bresp;
	assign s_axi_arready        = !s_r.rvalid;
	assign s_axi_rvalid         = s_r.rvalid;
	assign s_axi_rdata          = s_r.rdata;
	assign s_axi_rresp          = s_r.rresp;
	assign precision_osc_enable = s_r.ctrl[PREC_EN_BIT];
	assign watchdog_osc_enable  = s_r.ctrl[WDT_EN_BIT];
	// Clock tree muxes on this code; reserved codes pass through unchanged
	assign system_clock_select  = s_r.fallback ? SEL_WDT : s_r.ctrl[SEL_MSB:0];
	assign primary_fail_event   = s_r.pfail_evt;
	assign watchdog_fail_event  = s_r.wfail_evt;
	assign irq                  = |(s_r.status & s_r.mask);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_data_write;
		ctrl_wr && s_r.lock == UNLOCKED;
	endsequence

	sequence s_key2_taken;
		ctrl_wr && s_r.lock == KEY1_SEEN && s_r.wdata == UNLOCK_KEY2;
	endsequence

	a_unlock_then_store: assert property (@(posedge aclk) disable iff (!aresetn)
		s_data_write |=> s_r.ctrl == ($past(s_r.wdata) & CTRL_WMASK) && s_r.lock == LOCKED)
		else $error("Unlocked write not stored or not relocked");

	a_key_pair_unlocks: assert property (@(posedge aclk) disable iff (!aresetn)
		s_key2_taken |=> s_r.lock == UNLOCKED)
		else $error("Key pair did not unlock");

	a_unlock_from_key1: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(s_r.lock == UNLOCKED) |-> $past(s_r.lock) == KEY1_SEEN)
		else $error("Unlocked without first key");

	a_locked_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(s_r.ctrl) |-> $past(s_r.lock) == UNLOCKED && $past(ctrl_wr))
		else $error("Control changed while locked");

	a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && $past(rd_fire) && $past(s_axi_araddr) == CTRL_ADDR
		|-> s_axi_rdata[6] == 1'b0)
		else $error("Reserved bit read nonzero");

	a_enables_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		s_data_write |=> precision_osc_enable == $past(s_r.wdata[PREC_EN_BIT])
		&& watchdog_osc_enable == $past(s_r.wdata[WDT_EN_BIT]))
		else $error("Oscillator enable mismatch");

	a_pfail_gated: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(primary_fail_event) |-> $past(s_r.ctrl[PFD_EN_BIT]) && $past(primary_clock_failed))
		else $error("Primary failure event without detection enabled");

	a_wfail_gated: assert property (@(posedge aclk) disable iff (!aresetn)
		watchdog_fail_event |-> $past(s_r.ctrl[WFD_EN_BIT]))
		else $error("Watchdog failure event while detection off");

	a_wdt_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
		wdt_watch && s_r.wdt_cnt == WDT_LAST && !watchdog_osc_tick
		|=> watchdog_fail_event && s_r.status[WFAIL_BIT] ##1 !watchdog_fail_event)
		else $error("Watchdog timeout not reported once");

	a_fallback_select: assert property (@(posedge aclk) disable iff (!aresetn)
		pfail_now |=> primary_fail_event && system_clock_select == SEL_WDT)
		else $error("Primary failure did not switch to watchdog clock");

	a_clock_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		s_data_write ##1 !s_r.fallback |-> system_clock_select == $past(s_r.wdata[SEL_MSB:0]))
		else $error("Clock select does not follow written code");

	a_reset_value: assert property (@(posedge aclk)
		$rose(aresetn) |-> s_r.ctrl == CTRL_RESET && s_r.lock == LOCKED && !irq)
		else $error("Reset value wrong");

endmodule
`default_nettype wire

// ### test_oscillator_select_lock.sv
`timescale 1ns/1ps
`default_nettype none
module test_oscillator_select_lock
	import osc_ctl_pkg::*;
;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = 16'h0;
	logic              s_axi_awvalid = 1'b0;
	logic              s_axi_awready;
	logic [31:0]       s_axi_wdata = 32'h0;
	logic [3:0]        s_axi_wstrb = 4'h0;
	logic              s_axi_wvalid = 1'b0;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_bready = 1'b0;
	logic [ADDR_W-1:0] s_axi_araddr = 16'h0;
	logic              s_axi_arvalid = 1'b0;
	logic              s_axi_arready;
	logic [31:0]       s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              s_axi_rready = 1'b0;
	logic              primary_clock_failed = 1'b0;
	logic              watchdog_osc_tick = 1'b0;
	logic              precision_osc_enable;
	logic              watchdog_osc_enable;
	logic [2:0]        system_clock_select;
	logic              primary_fail_event;
	logic              watchdog_fail_event;
	logic              irq;
	int                n_mismatch = 0;
	int                tests_run = 0;
	int                n_pev = 0;
	int                n_wev = 0;
	logic [3:0]        wstrb_use = 4'h1;
	logic [7:0]        tv [6] = '{8'h00, 8'ha1, 8'h83, 8'h24, 8'hc7, 8'ha0};

	// Short failure limit keeps the watchdog run brief
	oscillator_select_lock #(.WDT_FAIL_LIMIT(16)) uut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .primary_clock_failed,
		.watchdog_osc_tick, .precision_osc_enable, .watchdog_osc_enable,
		.system_clock_select, .primary_fail_event, .watchdog_fail_event, .irq
	);

	// Clock and event counters; events are one-cycle pulses, so count them
	always #2.5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		if (primary_fail_event === 1'b1) n_pev++;
		if (watchdog_fail_event === 1'b1) n_wev++;
	end

	// ----------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Address and data are offered together and released one by one
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= wstrb_use;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge aclk);
			if (!aw && s_axi_awready === 1'b1)
			begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1)
			begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	// Read and compare data and response
	task automatic rdc(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		if (er === RESP_OKAY) chk("rdata", e, s_axi_rdata);
	endtask

	// Key pair, then the one effective write
	task automatic unl(input logic [7:0] d);
		wr(CTRL_ADDR, UNLOCK_KEY1, RESP_OKAY);
		wr(CTRL_ADDR, UNLOCK_KEY2, RESP_OKAY);
		wr(CTRL_ADDR, d, RESP_OKAY);
	endtask

	task automatic summarize;
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(CTRL_ADDR, 32'ha0, RESP_OKAY);
		chk("ctl_out", 32'h6, {29'h0, precision_osc_enable, watchdog_osc_enable, irq});
		wr(CTRL_ADDR, 8'h00, RESP_OKAY);
		rdc(CTRL_ADDR, 32'ha0, RESP_OKAY);
		// Wrong order and an interrupting value must both leave it locked
		wr(CTRL_ADDR, UNLOCK_KEY2, RESP_OKAY);
		wr(CTRL_ADDR, UNLOCK_KEY1, RESP_OKAY);
		wr(CTRL_ADDR, 8'h00, RESP_OKAY);
		wr(CTRL_ADDR, UNLOCK_KEY1, RESP_OKAY);
		wr(CTRL_ADDR, 8'h55, RESP_OKAY);
		wr(CTRL_ADDR, UNLOCK_KEY2, RESP_OKAY);
		wr(CTRL_ADDR, 8'h00, RESP_OKAY);
		rdc(CTRL_ADDR, 32'ha0, RESP_OKAY);
		// A status read between the keys does not break the sequence
		wr(CTRL_ADDR, UNLOCK_KEY1, RESP_OKAY);
		rdc(STATUS_ADDR, 32'h0, RESP_OKAY);
		wr(CTRL_ADDR, UNLOCK_KEY2, RESP_OKAY);
		wr(CTRL_ADDR, 8'h22, RESP_OKAY);
		rdc(CTRL_ADDR, 32'h22, RESP_OKAY);
		// Select codes 000, 001, 011, 100, 111 and every pattern of the two oscillator enables (bits 7 and 5), each write relocking
		foreach (tv[i])
		begin
			unl(tv[i]);
			rdc(CTRL_ADDR, {24'h0, tv[i] & CTRL_WMASK}, RESP_OKAY);
			chk("prec_en", {31'h0, tv[i][7]}, {31'h0, precision_osc_enable});
			chk("wdt_en", {31'h0, tv[i][5]}, {31'h0, watchdog_osc_enable});
			chk("sel", {29'h0, tv[i][2:0]}, {29'h0, system_clock_select});
		end
		wr(CTRL_ADDR, 8'h00, RESP_OKAY);
		rdc(CTRL_ADDR, 32'ha0, RESP_OKAY);
		// Keys with the low byte strobe off must not advance the sequencer
		wstrb_use = 4'h0;
		wr(CTRL_ADDR, UNLOCK_KEY1, RESP_OKAY);
		wr(CTRL_ADDR, UNLOCK_KEY2, RESP_OKAY);
		wstrb_use = 4'h1;
		wr(CTRL_ADDR, 8'h00, RESP_OKAY);
		rdc(CTRL_ADDR, 32'ha0, RESP_OKAY);
		wr(16'h0000, 8'h55, RESP_SLVERR);
		rdc(16'h0000, 32'h0, RESP_SLVERR);
		// Dead primary clock with detection off, then on
		unl(8'h20);
		primary_clock_failed <= 1'b1;
		cyc(20);
		chk("pev_off", 32'h0, n_pev);
		chk("wev_off", 32'h0, n_wev);
		unl(8'h30);
		cyc(4);
		chk("pev", 32'h1, n_pev);
		chk("sel_fb", {29'h0, SEL_WDT}, {29'h0, system_clock_select});
		chk("irq_mask", 32'h0, {31'h0, irq});
		wr(MASK_ADDR, 8'h03, RESP_OKAY);
		cyc(2);
		chk("irq_on", 32'h1, {31'h0, irq});
		rdc(STATUS_ADDR, 32'h1, RESP_OKAY);
		cyc(2);
		chk("irq_clr", 32'h0, {31'h0, irq});
		primary_clock_failed <= 1'b0;
		// Watchdog edges arriving in time, then none
		unl(8'h28);
		repeat (5)
		begin
			cyc(9);
			watchdog_osc_tick <= 1'b1;
			cyc(1);
			watchdog_osc_tick <= 1'b0;
		end
		cyc(13);
		chk("wev_early", 32'h0, n_wev);
		cyc(6);
		chk("wev", 32'h1, n_wev);
		chk("irq_wdt", 32'h1, {31'h0, irq});
		rdc(STATUS_ADDR, 32'h2, RESP_OKAY);
		summarize();
	end

	// A full pass needs well under 2000 cycles
	initial
	begin
		#20000;
		n_mismatch++;
		summarize();
	end

endmodule
`default_nettype wire
